/* File: ssp_consts.svh */
// ssp_consts.svh: offsets, fields, reset values and timing counts of the serial port controller
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// ----------------------------------------------------------------
// ports, rates and timing
// ----------------------------------------------------------------
`define SSP_NPORTS 8
`define SSP_CLK_HZ 50000000
`define SSP_RATE_HI_BPS 64000
`define SSP_RATE_LO_BPS 56000
`define SSP_BIT_HI_CYC (`SSP_CLK_HZ / `SSP_RATE_HI_BPS)
`define SSP_BIT_LO_CYC (`SSP_CLK_HZ / `SSP_RATE_LO_BPS)
`define SSP_BITS_HI_M1 3'h7
`define SSP_BITS_LO_M1 3'h6
`define SSP_LOC_US 100
`define SSP_LOC_CYC ((`SSP_LOC_US * `SSP_CLK_HZ + 999999) / 1000000)

// ----------------------------------------------------------------
// register offsets, fields and reset values
// ----------------------------------------------------------------
`define SSP_OFF_CONFIG 2'h0
`define SSP_OFF_STATUS 2'h1
`define SSP_OFF_MASK 2'h2
`define SSP_OFF_LEVEL 2'h3
`define SSP_CFG_W 4
`define SSP_ST_TXLOC 0
`define SSP_ST_RXLOC 8
`define SSP_ST_SLIP 16
`define SSP_CONFIG_RST 32'h0000_0000
`define SSP_MASK_RST 32'h0000_0000
`define SSP_RESP_OKAY 2'h0
`define SSP_RESP_SLVERR 2'h2

`endif

/* File: ssp_pkg.sv */
// ssp_pkg.sv: types shared by the serial port controller modules
package ssp_pkg;

	// per-port configuration nibble, rate flag in the lowest bit
	typedef struct packed {
		logic loop;
		logic reverse;
		logic dte;
		logic rate56;
	} ssp_cfg_s;

	// loss-of-clock detector answer
	typedef struct packed {
		logic lost;
		logic onset;
		logic clear;
	} ssp_loc_s;

endpackage

/* File: ssp_sync.sv */
// ssp_sync.sv: two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] d_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ssp_sync_s;

	ssp_sync_s st_reg;
	ssp_sync_s st_next;

	// first stage feeds only the second stage
	always_comb begin
		st_next.s1 = d_in;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign d_out = st_reg.s2;
endmodule
`default_nettype wire

/* File: ssp_loc.sv */
// ssp_loc.sv: loss-of-clock detector for one synchronised clock
`timescale 1ns/1ps
`default_nettype none
module ssp_loc #(
	parameter int LOC_CYCLES = 5000
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic clk_in,
	output ssp_pkg::ssp_loc_s loc
);
	localparam int CW = $clog2(LOC_CYCLES + 1);

	typedef struct packed {
		logic prev;
		logic [CW-1:0] cnt;
		ssp_pkg::ssp_loc_s loc;
	} ssp_loc_st_s;

	ssp_loc_st_s st_reg;
	ssp_loc_st_s st_next;

	if (LOC_CYCLES < 2) begin : g_chk
		$error("ssp_loc: LOC_CYCLES too small");
	end

	// count cycles without an edge; disabled detector stays silent
	always_comb begin
		st_next = st_reg;
		st_next.loc.onset = 1'b0;
		st_next.loc.clear = 1'b0;
		st_next.prev = clk_in;
		if (!enable) begin
			st_next.cnt = '0;
			st_next.loc.lost = 1'b0;
		end else if (clk_in != st_reg.prev) begin
			st_next.cnt = '0;
			if (st_reg.loc.lost) begin
				st_next.loc.lost = 1'b0;
				st_next.loc.clear = 1'b1;
			end
		end else if (st_reg.cnt == CW'(LOC_CYCLES - 1)) begin
			if (!st_reg.loc.lost) begin
				st_next.loc.lost = 1'b1;
				st_next.loc.onset = 1'b1;
			end
		end else begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign loc = st_reg.loc;
endmodule
`default_nettype wire

/* File: ssp_top.sv */
// ssp_top.sv: eight-port synchronous serial controller with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "ssp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ssp_top #(
	parameter int NPORTS = `SSP_NPORTS,
	parameter int ADDR_W = 8,
	parameter int LOC_CYCLES = `SSP_LOC_CYC
) (
	input wire logic CLK,
	input wire logic RST_B,
	// register bus
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic IRQ,
	// serial pins, one bit per port
	input wire logic [NPORTS-1:0] TX_TIMING_POS_I,
	output logic [NPORTS-1:0] TX_TIMING_POS_O,
	output logic [NPORTS-1:0] TX_TIMING_NEG_O,
	output logic [NPORTS-1:0] TX_TIMING_OE,
	input wire logic [NPORTS-1:0] RX_TIMING_POS_I,
	output logic [NPORTS-1:0] RX_TIMING_POS_O,
	output logic [NPORTS-1:0] RX_TIMING_NEG_O,
	output logic [NPORTS-1:0] RX_TIMING_OE,
	input wire logic [NPORTS-1:0] RX_SERIAL_POS_I,
	output logic [NPORTS-1:0] TX_SERIAL_POS_O,
	output logic [NPORTS-1:0] TX_SERIAL_NEG_O,
	// PCM time-slot side, one byte per port
	input wire logic PCM_FRAME,
	input wire logic [8*NPORTS-1:0] PCM_TX_BYTE,
	output logic [8*NPORTS-1:0] PCM_RX_BYTE
);
	// ----------------------------------------------------------------
	// types and elaboration checks
	// ----------------------------------------------------------------
	localparam logic [9:0] PER_HI = 10'(`SSP_BIT_HI_CYC);
	localparam logic [9:0] PER_LO = 10'(`SSP_BIT_LO_CYC);

	if (NPORTS < 1 || NPORTS > 8) begin : g_chk_ports
		$error("ssp_top: NPORTS must be 1..8");
	end
	if (ADDR_W < 4) begin : g_chk_addr
		$error("ssp_top: ADDR_W must be at least 4");
	end
	if (`SSP_BIT_LO_CYC > 1023 || LOC_CYCLES <= `SSP_BIT_LO_CYC) begin : g_chk_time
		$error("ssp_top: bit period or loss-of-clock count out of range");
	end

	typedef struct packed {
		logic [9:0] div;
		logic gen_clk;
		logic tclk_prev;
		logic rclk_prev;
		logic [2:0] cfg_seen;
		logic [7:0] rx_sr;
		logic [2:0] rx_cnt;
		logic [7:0] rx_hold;
		logic rx_full;
		logic [7:0] tx_sr;
		logic [2:0] tx_cnt;
		logic [7:0] tx_hold;
		logic tx_full;
		logic tx_bit;
		logic [7:0] pcm_rx;
	} ssp_port_s;

	typedef struct packed {
		ssp_port_s [NPORTS-1:0] port;
		logic [31:0] config_r;
		logic [31:0] status;
		logic [31:0] mask;
		logic aw_full;
		logic aw_ok;
		logic [1:0] aw_idx;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} ssp_state_s;

	ssp_state_s st_reg;
	ssp_state_s st_next;
	logic [NPORTS-1:0] tclk_s;
	logic [NPORTS-1:0] rclk_s;
	logic [NPORTS-1:0] rdat_s;
	logic [NPORTS-1:0] dte_vec;
	ssp_pkg::ssp_loc_s [NPORTS-1:0] tx_loc;
	ssp_pkg::ssp_loc_s [NPORTS-1:0] rx_loc;
	logic [NPORTS-1:0] loc_ev;

	// ----------------------------------------------------------------
	// pin synchronisers and loss-of-clock detectors
	// ----------------------------------------------------------------
	// every pin input crosses two flops before any port logic sees it
	ssp_sync #(.W(3 * NPORTS)) u_sync (
		.clk(CLK),
		.rst_b(RST_B),
		.d_in({RX_SERIAL_POS_I, RX_TIMING_POS_I, TX_TIMING_POS_I}),
		.d_out({rdat_s, rclk_s, tclk_s})
	);

	// separate detectors per direction, armed only for DTE ports
	for (genvar p = 0; p < NPORTS; p++) begin : g_loc
		assign dte_vec[p] = st_reg.config_r[`SSP_CFG_W * p + 1];
		assign loc_ev[p] = tx_loc[p].onset;
		ssp_loc #(.LOC_CYCLES(LOC_CYCLES)) u_tx_loc (
			.clk(CLK),
			.rst_b(RST_B),
			.enable(dte_vec[p]),
			.clk_in(tclk_s[p]),
			.loc(tx_loc[p])
		);
		ssp_loc #(.LOC_CYCLES(LOC_CYCLES)) u_rx_loc (
			.clk(CLK),
			.rst_b(RST_B),
			.enable(dte_vec[p]),
			.clk_in(rclk_s[p]),
			.loc(rx_loc[p])
		);
	end

	// ----------------------------------------------------------------
	// next state: ports, status and register bus
	// ----------------------------------------------------------------
	always_comb begin
		ssp_pkg::ssp_cfg_s cfg;
		logic [9:0] per;
		logic [2:0] last;
		logic t_fall;
		logic r_rise;
		logic [7:0] sr;
		logic [7:0] cur;
		logic [2:0] idx;
		logic [31:0] set;
		logic [31:0] w1c;
		logic [31:0] bmask;
		logic [7:0] tx_lost8;
		logic [7:0] rx_lost8;
		logic rd_ok;
		logic [1:0] rd_idx;
		cfg = '0;
		per = '0;
		last = '0;
		t_fall = 1'b0;
		r_rise = 1'b0;
		sr = '0;
		cur = '0;
		idx = '0;
		set = '0;
		w1c = '0;
		tx_lost8 = '0;
		rx_lost8 = '0;
		st_next = st_reg;
		bmask = {{8{st_reg.w_strb[3]}}, {8{st_reg.w_strb[2]}}, {8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
		rd_ok = (S_AXI_ARADDR[ADDR_W-1:4] == '0);
		rd_idx = S_AXI_ARADDR[3:2];

		for (int p = 0; p < NPORTS; p++) begin
			// each port decodes its own nibble of the config word
			cfg = ssp_pkg::ssp_cfg_s'(st_reg.config_r[`SSP_CFG_W * p +: `SSP_CFG_W]);
			per = cfg.rate56 ? PER_LO : PER_HI;
			last = cfg.rate56 ? `SSP_BITS_LO_M1 : `SSP_BITS_HI_M1;
			st_next.port[p].tclk_prev = tclk_s[p];
			st_next.port[p].rclk_prev = rclk_s[p];
			tx_lost8[p] = tx_loc[p].lost;
			rx_lost8[p] = rx_loc[p].lost;
			set[`SSP_ST_TXLOC + p] = tx_loc[p].onset | tx_loc[p].clear;
			set[`SSP_ST_RXLOC + p] = rx_loc[p].onset | rx_loc[p].clear;

			// clock selection: own divider in DCE, sampled pin edges in DTE
			if (!cfg.dte) begin
				st_next.port[p].div = (st_reg.port[p].div == per - 10'h001) ? 10'h000 : st_reg.port[p].div + 10'h001;
				st_next.port[p].gen_clk = (st_next.port[p].div < (per >> 1));
				t_fall = st_reg.port[p].gen_clk & ~st_next.port[p].gen_clk;
				r_rise = ~st_reg.port[p].gen_clk & st_next.port[p].gen_clk;
			end else begin
				st_next.port[p].div = '0;
				st_next.port[p].gen_clk = 1'b0;
				t_fall = st_reg.port[p].tclk_prev & ~tclk_s[p];
				r_rise = ~st_reg.port[p].rclk_prev & rclk_s[p];
			end

			// frame: hand the received byte to the highway, take the next one
			if (PCM_FRAME) begin
				if (cfg.loop) begin
					st_next.port[p].pcm_rx = PCM_TX_BYTE[8 * p +: 8];
				end else begin
					st_next.port[p].pcm_rx = st_reg.port[p].rx_hold;
					// no fresh byte: repeat the last one and, in DTE, note the slip
					set[`SSP_ST_SLIP + p] = set[`SSP_ST_SLIP + p] | (cfg.dte & ~st_reg.port[p].rx_full);
				end
				st_next.port[p].rx_full = 1'b0;
			end

			// receive shift register, first bit placed by the order setting
			if (r_rise) begin
				sr = cfg.reverse ? {rdat_s[p], st_reg.port[p].rx_sr[7:1]} : {st_reg.port[p].rx_sr[6:0], rdat_s[p]};
				st_next.port[p].rx_sr = sr;
				if (st_reg.port[p].rx_cnt == last) begin
					st_next.port[p].rx_cnt = '0;
					if (cfg.rate56) begin
						st_next.port[p].rx_hold = cfg.reverse ? {sr[7:1], 1'b0} : {sr[6:0], 1'b0};
					end else begin
						st_next.port[p].rx_hold = sr;
					end
					// unread byte overwritten: a slip in the receive direction
					set[`SSP_ST_SLIP + p] = set[`SSP_ST_SLIP + p] | (cfg.dte & st_next.port[p].rx_full);
					st_next.port[p].rx_full = 1'b1;
				end else begin
					st_next.port[p].rx_cnt = st_reg.port[p].rx_cnt + 3'h1;
				end
			end

			// transmit shift register, launched on the falling clock edge
			if (t_fall) begin
				cur = (st_reg.port[p].tx_cnt == 3'h0) ? st_reg.port[p].tx_hold : st_reg.port[p].tx_sr;
				if (st_reg.port[p].tx_cnt == 3'h0) begin
					st_next.port[p].tx_sr = st_reg.port[p].tx_hold;
					// empty hold: the old byte goes out again
					set[`SSP_ST_SLIP + p] = set[`SSP_ST_SLIP + p] | (cfg.dte & ~st_reg.port[p].tx_full);
					st_next.port[p].tx_full = 1'b0;
				end
				idx = cfg.reverse ? st_reg.port[p].tx_cnt + {2'h0, cfg.rate56} : 3'h7 - st_reg.port[p].tx_cnt;
				st_next.port[p].tx_bit = cur[idx];
				st_next.port[p].tx_cnt = (st_reg.port[p].tx_cnt == last) ? 3'h0 : st_reg.port[p].tx_cnt + 3'h1;
			end
			if (PCM_FRAME) begin
				st_next.port[p].tx_hold = PCM_TX_BYTE[8 * p +: 8];
				set[`SSP_ST_SLIP + p] = set[`SSP_ST_SLIP + p] | (cfg.dte & st_next.port[p].tx_full);
				st_next.port[p].tx_full = 1'b1;
			end

			// loopback ties the transmit pin to the receive pin, no buffers
			if (cfg.loop) begin
				st_next.port[p].tx_bit = rdat_s[p];
			end

			// a new rate, role or order drops buffered data and realigns
			if ({cfg.rate56, cfg.dte, cfg.reverse} != st_reg.port[p].cfg_seen) begin
				st_next.port[p] = '0;
				st_next.port[p].cfg_seen = {cfg.rate56, cfg.dte, cfg.reverse};
				set[`SSP_ST_SLIP + p] = 1'b0;
			end
		end

		// write channel: address and data taken in either order
		if (S_AXI_AWVALID && !st_reg.aw_full) begin
			st_next.aw_full = 1'b1;
			st_next.aw_ok = (S_AXI_AWADDR[ADDR_W-1:4] == '0);
			st_next.aw_idx = S_AXI_AWADDR[3:2];
		end
		if (S_AXI_WVALID && !st_reg.w_full) begin
			st_next.w_full = 1'b1;
			st_next.w_data = S_AXI_WDATA;
			st_next.w_strb = S_AXI_WSTRB;
		end
		if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
			st_next.aw_full = 1'b0;
			st_next.w_full = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = st_reg.aw_ok ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
			if (st_reg.aw_ok) begin
				case (st_reg.aw_idx)
					`SSP_OFF_CONFIG: st_next.config_r = (st_reg.config_r & ~bmask) | (st_reg.w_data & bmask);
					`SSP_OFF_STATUS: w1c = st_reg.w_data & bmask;
					`SSP_OFF_MASK: st_next.mask = (st_reg.mask & ~bmask) | (st_reg.w_data & bmask);
					default: w1c = '0;
				endcase
			end
		end else if (st_reg.bvalid && S_AXI_BREADY) begin
			st_next.bvalid = 1'b0;
		end

		// read channel: one read in flight, unmapped answers SLVERR
		if (S_AXI_ARVALID && !st_reg.rvalid) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = rd_ok ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
			st_next.rdata = '0;
			if (rd_ok) begin
				case (rd_idx)
					`SSP_OFF_CONFIG: st_next.rdata = st_reg.config_r;
					`SSP_OFF_STATUS: st_next.rdata = st_reg.status;
					`SSP_OFF_MASK: st_next.rdata = st_reg.mask;
					default: st_next.rdata = {16'h0000, rx_lost8, tx_lost8};
				endcase
			end
		end else if (st_reg.rvalid && S_AXI_RREADY) begin
			st_next.rvalid = 1'b0;
		end

		// sticky status: an event in the clearing cycle survives
		st_next.status = (st_reg.status & ~w1c) | set;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_reg <= '0;
			st_reg.config_r <= `SSP_CONFIG_RST;
			st_reg.mask <= `SSP_MASK_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign S_AXI_AWREADY = !st_reg.aw_full;
	assign S_AXI_WREADY = !st_reg.w_full;
	assign S_AXI_BVALID = st_reg.bvalid;
	assign S_AXI_BRESP = st_reg.bresp;
	assign S_AXI_ARREADY = !st_reg.rvalid;
	assign S_AXI_RVALID = st_reg.rvalid;
	assign S_AXI_RDATA = st_reg.rdata;
	assign S_AXI_RRESP = st_reg.rresp;
	assign IRQ = |(st_reg.status & st_reg.mask);

	// pairs driven as complements; only clock and data pins exist
	for (genvar p = 0; p < NPORTS; p++) begin : g_pins
		assign TX_TIMING_POS_O[p] = st_reg.port[p].gen_clk;
		assign TX_TIMING_NEG_O[p] = ~st_reg.port[p].gen_clk;
		assign RX_TIMING_POS_O[p] = st_reg.port[p].gen_clk;
		assign RX_TIMING_NEG_O[p] = ~st_reg.port[p].gen_clk;
		// clock pins turn around with the role; the received clock goes nowhere else
		assign TX_TIMING_OE[p] = ~dte_vec[p];
		assign RX_TIMING_OE[p] = ~dte_vec[p];
		assign TX_SERIAL_POS_O[p] = st_reg.port[p].tx_bit;
		assign TX_SERIAL_NEG_O[p] = ~st_reg.port[p].tx_bit;
		assign PCM_RX_BYTE[8 * p +: 8] = st_reg.port[p].pcm_rx;
	end

	// ----------------------------------------------------------------
	// checks on port 0, loss-of-clock checks on every port
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	ssp_pkg::ssp_cfg_s c0;
	assign c0 = ssp_pkg::ssp_cfg_s'(st_reg.config_r[`SSP_CFG_W-1:0]);

	AST_DCE_QUIET: assert property ((st_next.status[15:0] & ~st_reg.status[15:0] & {2{~8'(dte_vec)}}) == 16'h0000)
		else $error("loss-of-clock event on a DCE port");
	AST_DCE_CLOCK_RUNS: assert property (!c0.dte && $stable(st_reg.config_r) |-> ##[1:900] $changed(TX_TIMING_POS_O[0]))
		else $error("DCE clock did not toggle within a bit period");
	AST_LOOP_SERIAL: assert property (c0.loop && $stable(st_reg.config_r) |=> TX_SERIAL_POS_O[0] == $past(rdat_s[0]))
		else $error("serial loopback did not follow the receive pin");
	AST_LOOP_PCM: assert property (PCM_FRAME && c0.loop |=> PCM_RX_BYTE[7:0] == $past(PCM_TX_BYTE[7:0]))
		else $error("PCM loopback byte mismatch");
	AST_BIT0_ZERO: assert property (PCM_FRAME && c0.rate56 && !c0.loop |=> !PCM_RX_BYTE[0])
		else $error("56k byte has bit 0 set");
	// any DTE port: transmit-clock onset latched next cycle, and an unmasked one raises the interrupt
	AST_LOC_STICKY: assert property (|(loc_ev & dte_vec) |=>
		((st_reg.status[NPORTS-1:0] & $past(loc_ev)) == $past(loc_ev))
		&& (IRQ || ((st_reg.mask[NPORTS-1:0] & $past(loc_ev)) == '0)))
		else $error("loss-of-clock onset not latched");
	AST_SLIP_EMPTY: assert property (PCM_FRAME && c0.dte && !c0.loop && !st_reg.port[0].rx_full
		&& $stable(st_reg.config_r) |=> st_reg.status[`SSP_ST_SLIP])
		else $error("receive slip not reported");
	AST_FLUSH: assert property ($changed(st_reg.config_r[2:0]) |=> st_reg.port[0].rx_cnt == 3'h0 && !st_reg.port[0].rx_full)
		else $error("config change did not flush the port");
	// the cycle a rate change lands the counter is still the old one; the flush follows
	AST_BIT_COUNT: assert property ($stable(st_reg.config_r[0])
		|-> st_reg.port[0].rx_cnt <= (c0.rate56 ? `SSP_BITS_LO_M1 : `SSP_BITS_HI_M1))
		else $error("receive bit counter past byte length");
	COV_LOC_ONSET: cover property (|(loc_ev & dte_vec));
	COV_SLIP: cover property (st_reg.status[`SSP_ST_SLIP] && IRQ);
	COV_LOOP_FRAME: cover property (c0.loop && PCM_FRAME);
	COV_RX_BYTE: cover property (st_reg.port[0].rx_full && c0.reverse);
endmodule
`default_nettype wire

/* File: ssp_partner_model.sv */
// ssp_partner_model.sv: far-side serial equipment that supplies clocks and data
`timescale 1ns/1ps
`default_nettype none
module ssp_partner_model (
	input wire logic go,
	input wire logic [7:0] pat,
	input wire logic [3:0] nbits,
	output logic timing,
	output logic serial
);
	int i;
	// burst of clocked bits, first bit from pat[7], clock parked low between bursts
	initial begin
		timing = 1'b0;
		serial = 1'b0;
		forever begin
			@(posedge go);
			for (i = 0; i < nbits; i++) begin
				serial = pat[7 - i];
				#80 timing = 1'b1;
				#80 timing = 1'b0;
			end
			// released line shows the inverse so no stale bit can pass
			serial = ~serial;
		end
	end
endmodule
`default_nettype wire

/* File: test_sync_serial_port_controller.sv */
// test_sync_serial_port_controller.sv: self-checking bench for the serial port controller
`include "ssp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module test_sync_serial_port_controller;
	localparam int LOC = 1000;
	logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, frm, go;
	logic awready, wready, bvalid, arready, rvalid, irq, ptim, pser;
	logic [7:0] awaddr, araddr, pat, tti_tb, rti_tb, rsi_tb;
	logic [7:0] tto, ttn, toe, rto, rtn, roe, tso, tsn;
	logic [1:0] bresp, rresp;
	logic [3:0] wstrb, nb;
	logic [31:0] wdata, rdata, cfg, rd;
	logic [63:0] ptx, prx;
	int mismatches, total_checks;
	// port 1 faces the partner, the rest are driven here
	wire logic [7:0] tti = {tti_tb[7:2], ptim, tti_tb[0]};
	wire logic [7:0] rti = {rti_tb[7:2], ptim, rti_tb[0]};
	wire logic [7:0] rsi = {rsi_tb[7:2], pser, rsi_tb[0]};
	ssp_top #(.LOC_CYCLES(LOC)) dut_u (.CLK(clk), .RST_B(rst_b),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.IRQ(irq), .TX_TIMING_POS_I(tti), .TX_TIMING_POS_O(tto), .TX_TIMING_NEG_O(ttn),
		.TX_TIMING_OE(toe), .RX_TIMING_POS_I(rti), .RX_TIMING_POS_O(rto), .RX_TIMING_NEG_O(rtn),
		.RX_TIMING_OE(roe), .RX_SERIAL_POS_I(rsi), .TX_SERIAL_POS_O(tso), .TX_SERIAL_NEG_O(tsn),
		.PCM_FRAME(frm), .PCM_TX_BYTE(ptx), .PCM_RX_BYTE(prx));
	ssp_partner_model partner_u (.go(go), .pat(pat), .nbits(nb), .timing(ptim), .serial(pser));
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	always #10 clk = ~clk;
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h got %h", nm, e, g);
		end
	endtask
	// write: both channels offered together, each released when taken
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bready && bvalid) begin
				chk("bresp", er, bresp);
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task axr(input logic [7:0] a, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		while (!done) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rready && rvalid) begin
				rd = rdata;
				chk("rresp", er, rresp);
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task pframe(input logic [63:0] v);
		@(posedge clk);
		ptx <= v;
		frm <= 1'b1;
		@(posedge clk);
		frm <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task burst(input logic [7:0] v, input logic [3:0] n);
		@(posedge clk);
		pat <= v;
		nb <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (8 * n + 12) @(posedge clk);
	endtask
	// rise to rise of a generated clock, pair legs checked at the rise
	task per(input int p, output int n);
		int k;
		for (k = 0; k < 2000 && tto[p] !== 1'b0; k++) @(posedge clk);
		for (k = 0; k < 2000 && tto[p] !== 1'b1; k++) @(posedge clk);
		chk("pair", 3'b010, {ttn[p], rto[p], rtn[p]}); // legs inverse, rx same as tx
		n = 0;
		do begin @(posedge clk); n++; end while (tto[p] !== 1'b0 && n < 2000);
		do begin @(posedge clk); n++; end while (tto[p] !== 1'b1 && n < 2000);
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task t_regs();
		axr(8'h00, 2'h0); // config read
		chk("config", 32'h0, rd); // all DCE at reset
		axr(8'h40, 2'h2); // unmapped read
		chk("unmapped", 32'h0, rd); // no data
		axw(8'h40, 32'hffff_ffff, 2'h2); // unmapped write
		axw(8'h0c, 32'hffff_ffff, 2'h0); // read-only place
		axr(8'h0c, 2'h0); // level read
		chk("level", 32'h0, rd); // no loss in DCE
		chk("irq", 1'b0, irq); // quiet
		chk("oe", 8'hff, toe & roe); // DCE drives clocks
		$display("t_regs done");
	endtask
	task t_dce();
		int n;
		cfg[11:8] = 4'h1;
		axw(8'h00, cfg, 2'h0); // port 2 at 56k
		per(0, n);
		chk("period64", `SSP_BIT_HI_CYC, n); // 64k rate
		per(2, n);
		chk("period56", `SSP_BIT_LO_CYC, n); // 56k on one port only
		$display("t_dce done");
	endtask
	task t_loop();
		cfg[3:0] = 4'h8;
		axw(8'h00, cfg, 2'h0); // port 0 loop
		pframe(64'hc3);
		chk("pcm_loop", 8'hc3, prx[7:0]); // byte turned round
		rsi_tb[0] <= 1'b1;
		repeat (6) @(posedge clk);
		chk("ser_loop1", 2'b10, {tso[0], tsn[0]}); // echo high
		rsi_tb[0] <= 1'b0;
		repeat (6) @(posedge clk);
		chk("ser_loop0", 2'b01, {tso[0], tsn[0]}); // echo low
		cfg[3:0] = 4'h5;
		axw(8'h00, cfg, 2'h0); // port 0 reverse 56k, loop off
		repeat (2) @(posedge clk);
		chk("flush0", 8'h00, prx[7:0]); // looped byte dropped on order change
		pframe(64'hff);
		chk("rx56_0", 8'h00, prx[7:0]); // idle line, 56k bit 0 zero
		$display("t_loop done");
	endtask
	task t_dte_rx();
		logic [7:0] e;
		int k;
		cfg[7:4] = 4'h2;
		axw(8'h00, cfg, 2'h0); // port 1 DTE
		chk("oe_dte", 2'b00, {toe[1], roe[1]}); // clocks become inputs
		burst(8'ha5, 4'h8);
		pframe(64'h0);
		chk("rx64n", 8'ha5, prx[15:8]); // first bit at top
		cfg[7:4] = 4'h7;
		axw(8'h00, cfg, 2'h0); // reverse, 56k
		repeat (3) @(posedge clk);
		chk("flush", 8'h00, prx[15:8]); // port restarted
		burst(8'hb4, 4'h7);
		pframe(64'h0);
		e = 8'h00;
		for (k = 1; k < 8; k++) e[k] = pat[8 - k];
		chk("rx56r", e, prx[15:8]); // first bit at bit 1, bit 0 zero
		$display("t_dte_rx done");
	endtask
	task t_loc();
		axw(8'h04, 32'hffff_ffff, 2'h0); // sticky clear
		axw(8'h08, 32'h0000_0202, 2'h0); // unmask port 1
		repeat (LOC + 20) @(posedge clk);
		axr(8'h0c, 2'h0); // level read
		chk("lvl_lost", 32'h0202, rd); // only the DTE port
		axr(8'h04, 2'h0); // status read
		chk("st_onset", 32'h0202, rd & 32'hffff); // onset both ways
		chk("irq_on", 1'b1, irq); // raised
		axw(8'h08, 32'h0, 2'h0); // mask all
		chk("irq_mask", 1'b0, irq); // masked
		axw(8'h04, 32'hffff_ffff, 2'h0); // clear
		axw(8'h08, 32'h0000_0202, 2'h0); // unmask
		chk("irq_clr", 1'b0, irq); // cleared by write
		burst(8'h55, 4'h8);
		axr(8'h04, 2'h0); // status read
		chk("st_clear", 32'h0202, rd & 32'hffff); // clearing reported
		chk("irq_clear", 1'b1, irq); // raised again
		$display("t_loc done");
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// main sequence after six cycles of reset
	initial begin
		{clk, rst_b, awvalid, wvalid, bready, arvalid, rready, frm, go} = '0;
		{awaddr, araddr, wdata, ptx, tti_tb, rti_tb, rsi_tb, pat, nb, cfg} = '0;
		wstrb = 4'hf;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_dce();
		t_loop();
		t_dte_rx();
		t_loc();
		finish_test();
	end
	// watchdog well past the expected run of about four thousand cycles
	initial begin
		#400000;
		mismatches++;
		finish_test();
	end
endmodule
`default_nettype wire
